// File: aofc_composer.sv
// What this block does
// - MSB-first: top bit down to stop index
// - LSB-first: stop index up to top bit
// - Unclaimed frame positions send zero
// - Frame length is divider value plus one
// - Two control fields, each with enable
// - Control field placed at its position
// - Control fields use sample bit order
// - Control value write sets pending flag
// - Shadow load clears pending flag
// - Loaded control values repeat every frame
// - No interrupt; pending flag polled only
// - Same start: left, right, one, two
// - Later start cuts the earlier field
// - Reset clears enables, positions, pending flag
// - Frames run even with transmit disabled
// - First control pair sent next frame
// - One left, one right sample per frame
// - Samples start at their start positions
//
// Decided for this implementation: the APB interface to the registers and the address map.

`include "aofc_cfg.svh"

module aofc_composer
	import aofc_pkg::*;
#(
	parameter int SCK_HALF = 4
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire aofc_sample_type  sample_in,
	output logic                  sample_take,
	output logic                  serial_bit_clock,
	output logic                  word_select_line,
	output logic                  serial_data_outputs
);

	generate
		if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_bad
			$error("SCK_HALF must be 1 to 255");
		end
	endgenerate

	localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);

	aofc_state_type st_reg;
	aofc_state_type st_next;
	logic           acc;
	logic           wr;
	logic           map_hit;
	logic           adv;
	logic           frame_end;
	logic           load;
	aofc_pos_type   np;
	logic [1:0]     pick;
	logic           pick_ok;
	logic           pick_bit;
	logic           pick_in;

	// Bit k of a field running from top down to stop, or upward
	function automatic logic [1:0] fld_bit(
		input logic [31:0] w,
		input logic [4:0]  top,
		input logic [4:0]  stop,
		input logic        lsb,
		input aofc_pos_type k
	);
		logic [5:0] len;
		logic [4:0] idx;
		len = 6'(top) - 6'(stop) + 6'h01;
		idx = lsb ? 5'(stop + k[4:0]) : 5'(top - k[4:0]);
		fld_bit = {(k < aofc_pos_type'(len)) && (top >= stop), w[idx]};
	endfunction : fld_bit

	// Register decode
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `AOFC_CTL_ADDR) || (a == `AOFC_FRAME_ADDR)
			|| (a == `AOFC_DIV_ADDR) || (a == `AOFC_CCV_ADDR)
			|| (a == `AOFC_CCP_ADDR) || (a == `AOFC_STAT_ADDR);
	endfunction : is_mapped

	assign acc     = psel && penable;
	assign wr      = acc && pwrite;
	assign map_hit = is_mapped(paddr);
	assign pready  = 1'b1;
	assign pslverr = acc && !map_hit;

	assign adv       = (st_reg.div_cnt == HALF_M1) && st_reg.sck;
	assign np        = (st_reg.bit_pos == st_reg.frame_div) ? '0
		: aofc_pos_type'(st_reg.bit_pos + 1'b1);
	assign frame_end = adv && (np == st_reg.frame_div);
	assign load      = frame_end && st_reg.busy;

	// Field selection for the next frame position
	always_comb begin
		logic [3:0]   en;
		aofc_pos_type sp [4];
		logic [4:0]   top_s;
		logic [4:0]   stop_s;
		logic [1:0]   fb;
		fb      = 2'b00;
		en      = {st_reg.ctl.control_two_enable, st_reg.ctl.control_one_enable, 2'b11};
		sp[0]   = st_reg.left_pos;
		sp[1]   = st_reg.right_pos;
		sp[2]   = st_reg.control_one_position;
		sp[3]   = st_reg.control_two_position;
		top_s   = st_reg.ctl.wide ? `AOFC_TOP32 : `AOFC_TOP16;
		stop_s  = st_reg.ctl.wide ? st_reg.ctl.stop
			: {1'b0, st_reg.ctl.stop[3:0]};
		pick    = 2'd0;
		pick_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			// Strict compare keeps priority order on ties
			if (en[i] && sp[i] <= np && (!pick_in || sp[i] > sp[pick])) begin
				pick    = 2'(i);
				pick_in = 1'b1;
			end
		end
		case (pick)
			2'd0:    fb = fld_bit(st_reg.smp.left, top_s, stop_s,
				st_reg.ctl.lsb_first, aofc_pos_type'(np - sp[0]));
			2'd1:    fb = fld_bit(st_reg.smp.right, top_s, stop_s,
				st_reg.ctl.lsb_first, aofc_pos_type'(np - sp[1]));
			2'd2:    fb = fld_bit({16'h0000, st_reg.shad1}, `AOFC_CC_TOP,
				5'h00, st_reg.ctl.lsb_first, aofc_pos_type'(np - sp[2]));
			default: fb = fld_bit({16'h0000, st_reg.shad2}, `AOFC_CC_TOP,
				5'h00, st_reg.ctl.lsb_first, aofc_pos_type'(np - sp[3]));
		endcase
		pick_ok  = pick_in && fb[1];
		pick_bit = pick_ok && fb[0];
	end

	always_comb begin
		st_next      = st_reg;
		st_next.take = 1'b0;
		// Read data captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			case (paddr)
				`AOFC_CTL_ADDR:   st_next.rdata = 32'({st_reg.ctl.stop,
					2'b00, st_reg.ctl.word_select_pulse_mode, st_reg.ctl.control_two_enable,
					st_reg.ctl.control_one_enable, st_reg.ctl.wide,
					st_reg.ctl.lsb_first, st_reg.ctl.tx_en});
				`AOFC_FRAME_ADDR: st_next.rdata = {7'h00, st_reg.right_pos,
					7'h00, st_reg.left_pos};
				`AOFC_DIV_ADDR:   st_next.rdata = 32'(st_reg.frame_div);
				`AOFC_CCV_ADDR:   st_next.rdata = {st_reg.hold2, st_reg.hold1};
				`AOFC_CCP_ADDR:   st_next.rdata = {7'h00, st_reg.control_two_position,
					7'h00, st_reg.control_one_position};
				// Polled status only, no interrupt
				`AOFC_STAT_ADDR:  st_next.rdata = {7'h00, st_reg.bit_pos,
					15'h0000, st_reg.busy};
				default:          st_next.rdata = 32'h00000000;
			endcase
		end
		// Shadow transfer at the end of a frame while the pending flag is set
		if (load) begin
			st_next.shad1 = st_reg.hold1;
			st_next.shad2 = st_reg.hold2;
			st_next.busy  = 1'b0;
		end
		if (wr) begin
			case (paddr)
				`AOFC_CTL_ADDR: begin
					st_next.ctl.tx_en     = pwdata[`AOFC_CTL_TX];
					st_next.ctl.lsb_first = pwdata[`AOFC_CTL_LSB];
					st_next.ctl.wide      = pwdata[`AOFC_CTL_WIDE];
					st_next.ctl.control_one_enable    = pwdata[`AOFC_CTL_CC1EN];
					st_next.ctl.control_two_enable    = pwdata[`AOFC_CTL_CC2EN];
					st_next.ctl.word_select_pulse_mode  = pwdata[`AOFC_CTL_WSP];
					st_next.ctl.stop      = pwdata[`AOFC_CTL_STOP_LO +: 5];
				end
				`AOFC_FRAME_ADDR: begin
					st_next.left_pos  = pwdata[0 +: `AOFC_POS_W];
					st_next.right_pos = pwdata[`AOFC_POS_HI_LO +: `AOFC_POS_W];
				end
				`AOFC_DIV_ADDR: st_next.frame_div = pwdata[0 +: `AOFC_POS_W];
				`AOFC_CCV_ADDR: begin
					st_next.hold1 = pwdata[15:0];
					st_next.hold2 = pwdata[31:16];
					st_next.busy  = 1'b1;
				end
				`AOFC_CCP_ADDR: begin
					st_next.control_one_position = pwdata[0 +: `AOFC_POS_W];
					st_next.control_two_position = pwdata[`AOFC_POS_HI_LO +: `AOFC_POS_W];
				end
				default: ;
			endcase
		end
		// Bit clock divider, data moves on the falling edge
		if (st_reg.div_cnt == HALF_M1) begin
			st_next.div_cnt = 8'h00;
			st_next.sck     = !st_reg.sck;
		end else begin
			st_next.div_cnt = 8'(st_reg.div_cnt + 1'b1);
		end
		// Frames run regardless of transmit enable
		if (adv) begin
			st_next.bit_pos = np;
			st_next.sd      = pick_bit;
			st_next.hit     = pick_ok;
			st_next.sel     = pick;
			st_next.ws      = st_reg.ctl.word_select_pulse_mode ? (np == '0)
				: (np > (st_reg.frame_div >> 1));
		end
		// One sample pair per frame, zero when disabled
		if (frame_end) begin
			st_next.smp  = st_reg.ctl.tx_en ? sample_in : '0;
			st_next.take = st_reg.ctl.tx_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{frame_div: `AOFC_DIV_RST, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata              = st_reg.rdata;
	assign sample_take         = st_reg.take;
	assign serial_bit_clock    = st_reg.sck;
	assign word_select_line    = st_reg.ws;
	assign serial_data_outputs = st_reg.sd;

	property p_busy_set;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == `AOFC_CCV_ADDR |=> st_reg.busy;
	endproperty
	a_busy_set: assert property (p_busy_set)
		else $error("pending flag not set by control write");

	property p_busy_clear;
		@(posedge pclk) disable iff (!presetn)
		load && !(wr && paddr == `AOFC_CCV_ADDR)
		|=> !st_reg.busy && st_reg.shad1 == $past(st_reg.hold1)
		&& st_reg.shad2 == $past(st_reg.hold2);
	endproperty
	a_busy_clear: assert property (p_busy_clear)
		else $error("shadow load did not clear pending flag");

	property p_shadow_keep;
		@(posedge pclk) disable iff (!presetn)
		!load |=> $stable(st_reg.shad1) && $stable(st_reg.shad2);
	endproperty
	a_shadow_keep: assert property (p_shadow_keep)
		else $error("shadow changed outside frame end");

	property p_frame_wrap;
		@(posedge pclk) disable iff (!presetn)
		adv && st_reg.bit_pos == st_reg.frame_div |=> st_reg.bit_pos == '0;
	endproperty
	a_frame_wrap: assert property (p_frame_wrap)
		else $error("frame did not wrap after divider value");

	property p_runs_idle;
		@(posedge pclk) disable iff (!presetn)
		adv && !st_reg.ctl.tx_en && st_reg.bit_pos != st_reg.frame_div
		|=> st_reg.bit_pos == $past(st_reg.bit_pos) + 1'b1;
	endproperty
	a_runs_idle: assert property (p_runs_idle)
		else $error("frame stalled with transmit disabled");

	property p_zero_fill;
		@(posedge pclk) disable iff (!presetn)
		!st_reg.hit |-> !st_reg.sd;
	endproperty
	a_zero_fill: assert property (p_zero_fill)
		else $error("unclaimed position not zero");

	property p_left_first;
		@(posedge pclk) disable iff (!presetn)
		adv && np == st_reg.left_pos |=> st_reg.sel == 2'd0;
	endproperty
	a_left_first: assert property (p_left_first)
		else $error("left field lost priority at its start");

	property p_reset_vals;
		@(posedge pclk)
		!presetn |=> !st_reg.busy && !st_reg.ctl.control_one_enable && !st_reg.ctl.control_two_enable
		&& st_reg.control_one_position == '0 && st_reg.control_two_position == '0;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");

	property p_take_once;
		@(posedge pclk) disable iff (!presetn)
		st_reg.take |-> st_reg.bit_pos == st_reg.frame_div ##1 !st_reg.take;
	endproperty
	a_take_once: assert property (p_take_once)
		else $error("sample taken away from frame end");

	property p_idle_zero;
		@(posedge pclk) disable iff (!presetn)
		frame_end && !st_reg.ctl.tx_en |=> st_reg.smp == '0 && !st_reg.take;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("samples not zeroed with transmit disabled");

endmodule : aofc_composer

// File: aofc_cfg.svh
`ifndef AOFC_CFG_SVH
`define AOFC_CFG_SVH

`define AOFC_ADDR_W      12
`define AOFC_POS_W       9
`define AOFC_CTL_ADDR    12'h000
`define AOFC_FRAME_ADDR  12'h004
`define AOFC_DIV_ADDR    12'h008
`define AOFC_CCV_ADDR    12'h00C
`define AOFC_CCP_ADDR    12'h010
`define AOFC_STAT_ADDR   12'h014

`define AOFC_CTL_TX      0
`define AOFC_CTL_LSB     1
`define AOFC_CTL_WIDE    2
`define AOFC_CTL_CC1EN   3
`define AOFC_CTL_CC2EN   4
`define AOFC_CTL_WSP     5
`define AOFC_CTL_STOP_LO 8
`define AOFC_POS_HI_LO   16
`define AOFC_STAT_POS_LO 16

`define AOFC_DIV_RST     9'h03F
`define AOFC_CC_TOP      5'h0F
`define AOFC_TOP16       5'h0F
`define AOFC_TOP32       5'h1F

`endif

// File: aofc_pkg.sv
package aofc_pkg;
`include "aofc_cfg.svh"

	typedef logic [`AOFC_POS_W-1:0] aofc_pos_type;

	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} aofc_sample_type;

	typedef struct packed {
		logic       tx_en;
		logic       lsb_first;
		logic       wide;
		logic       control_one_enable;
		logic       control_two_enable;
		logic       word_select_pulse_mode;
		logic [4:0] stop;
	} aofc_ctl_type;

	typedef struct packed {
		aofc_ctl_type    ctl;
		aofc_pos_type    left_pos;
		aofc_pos_type    right_pos;
		aofc_pos_type    control_one_position;
		aofc_pos_type    control_two_position;
		aofc_pos_type    frame_div;
		aofc_pos_type    bit_pos;
		logic [15:0]     hold1;
		logic [15:0]     hold2;
		logic [15:0]     shad1;
		logic [15:0]     shad2;
		logic            busy;
		aofc_sample_type smp;
		logic [7:0]      div_cnt;
		logic            sck;
		logic            ws;
		logic            sd;
		logic            hit;
		logic [1:0]      sel;
		logic            take;
		logic [31:0]     rdata;
	} aofc_state_type;

endpackage : aofc_pkg

// File: aofc_dac_model.sv
module aofc_dac_model (
	input  wire logic         sck,
	input  wire logic         ws,
	input  wire logic         sd,
	input  wire logic         pulse,
	output logic      [511:0] last_frame,
	output logic      [511:0] last_ws,
	output int                last_len,
	output int                frames
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [511:0] cur;
	logic [511:0] cur_ws;
	logic         ws_q;
	logic         start;
	int           idx;
	initial begin
		cur = '0;
		cur_ws = '0;
		ws_q = 1'b0;
		idx = 0;
		frames = 0;
		last_len = 0;
		last_frame = '0;
		last_ws = '0;
	end
	// Position 0: word select pulse, or falling word select in 50% mode
	assign start = pulse ? (ws === 1'b1) : (ws_q === 1'b1 && ws === 1'b0);
	// Samples data on rising bit clock
	always @(posedge sck) begin
		ws_q <= ws;
		if (start) begin
			last_frame <= cur;
			last_ws <= cur_ws;
			last_len <= idx;
			frames <= frames + 1;
			cur <= '0;
			cur[0] <= sd;
			cur_ws <= '0;
			cur_ws[0] <= ws;
			idx <= 1;
		end else begin
			cur[idx[8:0]] <= sd;
			cur_ws[idx[8:0]] <= ws;
			idx <= idx + 1;
		end
	end
endmodule : aofc_dac_model

// File: tb_audio_out_frame_composer.sv
module tb_audio_out_frame_composer import aofc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [31:0] ctl, pos, div, ccp, ccv;
		int          len;
	} aofc_row_type;
	localparam logic [31:0] SL = 32'hC3A5_96F1;
	localparam logic [31:0] SR = 32'h5A0F_E817;
	logic            pclk, presetn, psel, penable, pwrite;
	logic            pready, pslverr, sample_take, sck, ws, sd, err;
	logic            word_select_pulse_mode_mode;
	logic [11:0]     paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic [511:0]    frame, ws_frame;
	aofc_sample_type smp;
	int              flen, frames, fail_count, n_checks, takes;
	aofc_row_type    rows [8] = '{
		'{32'h021, 32'h0020_0000, 32'h3F, 32'h0, 32'hBEEF_1234, 64},
		'{32'h427, 32'h0028_0002, 32'h47, 32'h0, 32'h0F0F_A5A5, 72},
		'{32'h03D, 32'h0014_0000, 32'h3F, 32'h003C_0000, 32'h8001_7FFE, 64},
		'{32'h039, 32'h0020_0000, 32'h3F, 32'h0030_0010, 32'hC0DE_5A3C, 64},
		'{32'h32B, 32'h0020_0000, 32'h3F, 32'h0000_0014, 32'h1357_9BDF, 64},
		'{32'h038, 32'h0020_0000, 32'h3F, 32'h0030_0010, 32'hA0A0_0505, 64},
		'{32'h021, 32'h0012_0000, 32'h23, 32'h0, 32'h7E7E_0101, 36},
		'{32'h00B, 32'h0020_0000, 32'h3F, 32'h0000_0030, 32'h2468_ACE0, 64}
	};
	aofc_composer #(.SCK_HALF(2)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_in(smp),
		.sample_take(sample_take), .serial_bit_clock(sck),
		.word_select_line(ws), .serial_data_outputs(sd)
	);
	aofc_dac_model u_dac (
		.sck(sck), .ws(ws), .sd(sd), .pulse(word_select_pulse_mode_mode),
		.last_frame(frame), .last_ws(ws_frame),
		.last_len(flen), .frames(frames)
	);
	always #4 pclk = ~pclk;
	// Counts sample pair hand-overs
	always @(posedge pclk) begin
		if (sample_take === 1'b1) begin
			takes <= takes + 1;
		end
	end
	task automatic end_sim;
		if (fail_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [511:0] got, input logic [511:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wf(input int n);
		int f0;
		f0 = frames;
		wait (frames >= f0 + n);
	endtask : wf
	function automatic logic [511:0] exp_frame(aofc_row_type r);
		logic [31:0]  v [4];
		int           st [4], tp [4], sp [4];
		logic         en [4];
		int           b, k;
		logic [511:0] e;
		e = '0;
		v = '{r.ctl[0] ? SL : '0, r.ctl[0] ? SR : '0,
			r.ccv[15:0], r.ccv[31:16]};
		st = '{r.pos[8:0], r.pos[24:16], r.ccp[8:0], r.ccp[24:16]};
		en = '{1'b1, 1'b1, r.ctl[3], r.ctl[4]};
		for (int f = 0; f < 4; f++) begin
			tp[f] = (f < 2 && r.ctl[2]) ? 31 : 15;
			sp[f] = (f > 1) ? 0 : (r.ctl[2] ? r.ctl[12:8] : r.ctl[11:8]);
		end
		for (int p = 0; p <= r.div; p++) begin
			b = -1;
			for (int f = 0; f < 4; f++) begin
				if (en[f] && st[f] <= p && (b < 0 || st[f] > st[b])) b = f;
			end
			if (b >= 0) begin
				k = p - st[b];
				if (k <= tp[b] - sp[b]) begin
					e[p] = r.ctl[1] ? v[b][sp[b] + k] : v[b][tp[b] - k];
				end
			end
		end
		return e;
	endfunction : exp_frame
	function automatic logic [511:0] exp_ws(aofc_row_type r);
		logic [511:0] e;
		e = '0;
		for (int p = 0; p <= r.div; p++) begin
			e[p] = r.ctl[5] ? (p == 0) : (p > r.div / 2);
		end
		return e;
	endfunction : exp_ws
	task automatic run_row(aofc_row_type r);
		int t0;
		word_select_pulse_mode_mode <= r.ctl[5];
		apb(1'b1, 12'h000, r.ctl);
		apb(1'b1, 12'h004, r.pos);
		apb(1'b1, 12'h008, r.div);
		apb(1'b1, 12'h010, r.ccp);
		wf(3);
		apb(1'b1, 12'h00C, r.ccv);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd[0], 1'b1);
		for (int i = 0; i < 400 && rd[0] !== 1'b0; i++) begin
			apb(1'b0, 12'h014, 32'h0);
		end
		chk(rd[0], 1'b0);
		wf(2);
		chk(frame, exp_frame(r));
		chk(ws_frame, exp_ws(r));
		chk(flen, r.len);
		t0 = takes;
		wf(1);
		chk(frame, exp_frame(r));
		chk(32'(takes - t0), {31'h0, r.ctl[0]});
	endtask : run_row
	initial begin
		repeat (80000) @(posedge pclk);
		fail_count++;
		end_sim();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		word_select_pulse_mode_mode = 1'b0;
		smp = '{left: SL, right: SR};
		fail_count = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd[0], 1'b0);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h3F);
		apb(1'b0, 12'h020, 32'h0);
		chk({rd, err}, {32'h0, 1'b1});
		foreach (rows[i]) run_row(rows[i]);
		end_sim();
	end
endmodule : tb_audio_out_frame_composer
